// file: rtl/lcsc_map.svh
`ifndef LCSC_MAP_SVH
`define LCSC_MAP_SVH

// clock and time base
`define LCSC_CLK_HZ            200000000
`define LCSC_TICK_HZ           1000
`define LCSC_TICK_DIV          (`LCSC_CLK_HZ / `LCSC_TICK_HZ)
// minutes, microseconds, hertz
`define LCSC_PREQUAL_MIN       33
`define LCSC_TOPOFF_MIN        33
`define LCSC_FAST_MIN          660
`define LCSC_SOFTSTART_US      2600
`define LCSC_BLINK_HZ          2
// ticks at 1 kHz
`define LCSC_MIN_TICKS         (60 * `LCSC_TICK_HZ)
`define LCSC_PREQUAL_TICKS     (`LCSC_PREQUAL_MIN * `LCSC_MIN_TICKS)
`define LCSC_TOPOFF_TICKS      (`LCSC_TOPOFF_MIN * `LCSC_MIN_TICKS)
`define LCSC_FAST_TICKS        (`LCSC_FAST_MIN * `LCSC_MIN_TICKS)
`define LCSC_SOFTSTART_TICKS   ((`LCSC_SOFTSTART_US * `LCSC_TICK_HZ + 999999) / 1000000)
`define LCSC_BLINK_HALF_TICKS  (`LCSC_TICK_HZ / (2 * `LCSC_BLINK_HZ))
// input limit decode, mA
`define LCSC_LIM_CODE_1000     2'b00
`define LCSC_LIM_CODE_475      2'b01
`define LCSC_LIM_CODE_95       2'b10
`define LCSC_LIM_CODE_SUSPEND  2'b11
`define LCSC_LIM_MA_1000       11'h3E8
`define LCSC_LIM_MA_475        11'h1DB
`define LCSC_LIM_MA_95         11'h05F
`define LCSC_LIM_MA_ZERO       11'h000
// die temperature taper, degrees C
`define LCSC_TEMP_LO           8'h64
`define LCSC_TEMP_HI           8'h78
`define LCSC_TEMP_SPAN         8'h14
// charge current supported range, mA
`define LCSC_ICHG_MIN          11'h0C8
`define LCSC_ICHG_MAX          11'h3E8
`define LCSC_DEGLITCH_TICKS    4

`endif

// file: rtl/lcsc_pkg.sv
package lcsc_pkg;
    typedef enum logic [5:0] {
        LCSC_IDLE    = 6'b000001,
        LCSC_PREQUAL = 6'b000010,
        LCSC_FAST    = 6'b000100,
        LCSC_TOPOFF  = 6'b001000,
        LCSC_DONE    = 6'b010000,
        LCSC_FAULT   = 6'b100000
    } lcsc_state_t;

    typedef logic [10:0] lcsc_ma_t;
endpackage

// file: rtl/lcsc_buck_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lcsc_buck_if;
    logic       tick;
    logic       enable;
    logic       railOk;
    logic       sequenced;
    logic [2:0] on;
    logic [2:0] ramping;

    modport ctrl (output tick, output enable, output railOk, output sequenced,
                  input on, input ramping);
    modport buck (input tick, input enable, input railOk, input sequenced,
                  output on, output ramping);
endinterface
`default_nettype wire

// file: rtl/lcsc_buck_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "lcsc_map.svh"
module lcsc_buck_seq (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_b,
    // control
    lcsc_buck_if.buck bus
);
    localparam int SS_TICKS = `LCSC_SOFTSTART_TICKS;

    logic [11:0] rampCount;
    logic [1:0]  stage;
    logic        allowed;
    logic        rampDone;
    logic [2:0]  next_on;

    assign allowed  = bus.enable && bus.railOk; // RQ19 RQ24
    assign rampDone = (rampCount == 12'(SS_TICKS - 1)) && bus.tick;

    // sequenced variant ramps one at a time
    always_comb begin
        if (!allowed) begin
            next_on = 3'h0;
        end else if (bus.sequenced) begin
            next_on = 3'h1 << stage;
        end else begin
            next_on = 3'h7;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rampCount   <= 12'h000;
            stage       <= 2'h0;
            bus.on      <= 3'h0;
            bus.ramping <= 3'h0;
        end else if (!allowed) begin
            rampCount   <= 12'h000;
            stage       <= 2'h0;
            bus.on      <= 3'h0; // RQ19
            bus.ramping <= 3'h0;
        end else begin
            bus.on <= bus.on | next_on;
            if (stage != 2'h3) begin
                bus.ramping <= next_on;
                if (rampDone) begin // RQ20
                    rampCount <= 12'h000;
                    stage     <= bus.sequenced ? stage + 2'h1 : 2'h3;
                end else if (bus.tick) begin
                    rampCount <= rampCount + 12'h001;
                end
            end else begin
                bus.ramping <= 3'h0;
            end
        end
    end
endmodule
`default_nettype wire

// file: rtl/lcsc_charge_ctrl.sv
// Notes on behaviour
// (RQ1) limit code 00=1000mA 01=475mA 10=95mA 11=suspend.
// (RQ2) enable rise with valid input starts a cycle.
// (RQ3) battery under 3.0V: prequal at 10% current.
// (RQ4) battery at 3.0V: fast charge at full current.
// (RQ5) current at 10%: 33min top-off, then done.
// (RQ6) done, battery 100mV low: restart, timers reset.
// (RQ7) invalid input or enable low stops charging.
// (RQ8) status low in prequal and fast charge.
// (RQ9) timer expiry faults, 2Hz blink, cleared by disable.
// (RQ10) prequal times out at 33min.
// (RQ11) fast charge times out at 660min.
// (RQ12) fast timer full rate at 50-100% current.
// (RQ13) fast timer half rate at 20-50% current.
// (RQ14) fast timer paused below 20% current.
// (RQ15) constant voltage: fast timer full rate.
// (RQ16) system load first; charge fits the limit.
// (RQ17) limit tapers to zero from 100C to 120C.
// (RQ18) prequal and top-off 10%; maximum 200-1000mA.
// (RQ19) converters off with rail below 2.55V.
// (RQ20) 2.6ms soft-start; sequenced variant ramps in turn.
// (RQ21) fixed 2MHz switching above about 80mA.
// (RQ22) limit pins deglitched against brief suspend.
// (RQ23) input invalid below 4V or below battery.
// (RQ24) buck enable switches all three converters.
// (RQ25) one slow time base; comparators synchronised.
`timescale 1ns/1ps
`default_nettype none
`include "lcsc_map.svh"
module lcsc_charge_ctrl #(
    parameter int TICK_DIV      = `LCSC_TICK_DIV,
    parameter int PREQUAL_TICKS = `LCSC_PREQUAL_TICKS,
    parameter int TOPOFF_TICKS  = `LCSC_TOPOFF_TICKS,
    parameter int FAST_TICKS    = `LCSC_FAST_TICKS
) (
    // clock and reset
    input  wire logic                clock,
    input  wire logic                rst_b,
    // host pins
    input  wire logic                charge_enable_in,
    input  wire logic                limit_select_hi,
    input  wire logic                limit_select_lo,
    input  wire logic                buck_enable,
    input  wire logic                sequencedVariant,
    // analog comparator flags
    input  wire logic                inputAbove4v,
    input  wire logic                inputAboveBattery,
    input  wire logic                batteryAbove3v,
    input  wire logic                batteryBelowRestart,
    input  wire logic                constantVoltage,
    input  wire logic                systemRailOk,
    // measured quantities
    input  wire logic [10:0]         charge_current_set,
    input  wire logic [10:0]         chargeCurrentMeas,
    input  wire logic [10:0]         system_load_current,
    input  wire logic [7:0]          dieTemp,
    input  wire logic [2:0]          buckLoad80ma,
    // charger outputs
    output logic                     charge_status_n_out,
    output logic                     charge_status_n_oe,
    output logic [10:0]              chargeCurrentCmd,
    output logic [10:0]              inputLimitMa,
    output logic                     inputConnected,
    output logic                     chargerOn,
    output logic                     faultLatched,
    output lcsc_pkg::lcsc_state_t    chargeState,
    // converter outputs
    output logic                     buck_one,
    output logic                     buck_two,
    output logic                     buck_three,
    output logic [2:0]               buckRamping,
    output logic [2:0]               buckPwm
);
    localparam int BLINK_HALF = `LCSC_BLINK_HALF_TICKS;

    // 10% of a current in mA, integer
    function automatic lcsc_pkg::lcsc_ma_t tenth(input lcsc_pkg::lcsc_ma_t v);
        tenth = 11'(v / 11'd10);
    endfunction

    // three-flop pin synchroniser
    localparam int NSYNC = 14;
    logic [NSYNC-1:0] rawIn;
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic [NSYNC-1:0] s3;
    logic [NSYNC-1:0] clean;
    assign rawIn = {charge_enable_in, buckLoad80ma, sequencedVariant, systemRailOk,
                    constantVoltage, batteryBelowRestart, batteryAbove3v, inputAboveBattery,
                    inputAbove4v, buck_enable, limit_select_lo, limit_select_hi};
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s1    <= '0;
            s2    <= '0;
            s3    <= '0;
            clean <= '0;
        end else begin
            s1    <= rawIn;
            s2    <= s1;
            s3    <= s2;
            clean <= (s2 & s3) | (clean & (s2 | s3)); // RQ25
        end
    end

    wire logic [1:0] limRaw    = {clean[0], clean[1]}; // RQ1
    wire logic       ceClean   = clean[13];
    wire logic       buckEnS   = clean[2];
    wire logic       in4v      = clean[3];
    wire logic       inAbvBat  = clean[4];
    wire logic       bat3v     = clean[5];
    wire logic       batLow    = clean[6];
    wire logic       cvMode    = clean[7];
    wire logic       railOk    = clean[8];
    wire logic       seqVar    = clean[9];
    wire logic [2:0] loadHigh  = clean[12:10];

    // slow time base, one-cycle enable
    logic [31:0] divCount;
    logic        tick;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            divCount <= 32'h0000_0000;
            tick     <= 1'b0;
        end else if (divCount == 32'(TICK_DIV - 1)) begin
            divCount <= 32'h0000_0000;
            tick     <= 1'b1; // RQ25
        end else begin
            divCount <= divCount + 32'h0000_0001;
            tick     <= 1'b0;
        end
    end

    // limit code must hold steady before it is taken
    logic [1:0] limCode;
    logic [1:0] limCand;
    logic [2:0] limAge;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            limCode <= `LCSC_LIM_CODE_1000;
            limCand <= `LCSC_LIM_CODE_1000;
            limAge  <= 3'h0;
        end else if (limRaw != limCand) begin
            limCand <= limRaw;
            limAge  <= 3'h0;
        end else if (tick) begin
            if (limAge == 3'(`LCSC_DEGLITCH_TICKS - 1)) begin
                limCode <= limCand; // RQ22
            end else begin
                limAge <= limAge + 3'h1;
            end
        end
    end

    wire logic suspended  = (limCode == `LCSC_LIM_CODE_SUSPEND); // RQ1
    wire logic inputValid = in4v && inAbvBat; // RQ23
    wire logic allowed    = inputValid && !suspended && ceClean; // RQ7

    // RQ1
    wire lcsc_pkg::lcsc_ma_t baseLimit =
        (limCode == `LCSC_LIM_CODE_1000) ? `LCSC_LIM_MA_1000 :
        (limCode == `LCSC_LIM_CODE_475)  ? `LCSC_LIM_MA_475  :
        (limCode == `LCSC_LIM_CODE_95)   ? `LCSC_LIM_MA_95   : `LCSC_LIM_MA_ZERO;

    // linear thermal taper
    wire logic [7:0]  tempOver = dieTemp - `LCSC_TEMP_LO;
    wire logic [18:0] tapered  = 19'(baseLimit) * 19'(`LCSC_TEMP_SPAN - tempOver);
    wire lcsc_pkg::lcsc_ma_t thermLimit =
        (dieTemp <= `LCSC_TEMP_LO) ? baseLimit :
        (dieTemp >= `LCSC_TEMP_HI) ? `LCSC_LIM_MA_ZERO :
        11'(tapered / 19'(`LCSC_TEMP_SPAN)); // RQ17

    // programmed maximum clamped to supported range
    wire lcsc_pkg::lcsc_ma_t progMax =
        (charge_current_set < `LCSC_ICHG_MIN) ? `LCSC_ICHG_MIN :
        (charge_current_set > `LCSC_ICHG_MAX) ? `LCSC_ICHG_MAX : charge_current_set; // RQ18
    wire lcsc_pkg::lcsc_ma_t tenthMax = tenth(progMax); // RQ18

    // system load served first, battery gets the rest
    wire lcsc_pkg::lcsc_ma_t headroom =
        (system_load_current >= thermLimit) ? `LCSC_LIM_MA_ZERO
                                             : thermLimit - system_load_current; // RQ16

    // state machine
    lcsc_pkg::lcsc_state_t state;
    lcsc_pkg::lcsc_state_t next_state;
    logic [31:0] timer;
    logic        halfPhase;
    logic        enPrev;
    wire logic   startEdge = allowed && !enPrev; // RQ2

    wire logic currentAtTopoff = chargeCurrentMeas <= tenthMax;
    wire logic aboveHalf       = {chargeCurrentMeas, 1'b0} >= {1'b0, progMax};
    wire logic above20 = 14'(chargeCurrentMeas) * 14'h5 >= 14'(progMax);

    // fast timer rate selection
    wire logic fastAdvance = cvMode ? 1'b1 :            // RQ15
                             aboveHalf ? 1'b1 :         // RQ12
                             above20 ? halfPhase :      // RQ13
                             1'b0;                      // RQ14

    wire logic preqExpired = timer >= 32'(PREQUAL_TICKS - 1);
    wire logic fastExpired = timer >= 32'(FAST_TICKS - 1);
    wire logic topExpired  = timer >= 32'(TOPOFF_TICKS - 1);

    always_comb begin
        next_state = state;
        if (!allowed) begin
            next_state = lcsc_pkg::LCSC_IDLE; // RQ7 RQ9
        end else begin
            unique case (state)
                lcsc_pkg::LCSC_IDLE: begin
                    if (startEdge) begin
                        next_state = bat3v ? lcsc_pkg::LCSC_FAST : lcsc_pkg::LCSC_PREQUAL; // RQ3
                    end
                end
                lcsc_pkg::LCSC_PREQUAL: begin
                    if (tick && preqExpired) begin
                        next_state = lcsc_pkg::LCSC_FAULT; // RQ10
                    end else if (bat3v) begin
                        next_state = lcsc_pkg::LCSC_FAST; // RQ4
                    end
                end
                lcsc_pkg::LCSC_FAST: begin
                    if (tick && fastAdvance && fastExpired) begin
                        next_state = lcsc_pkg::LCSC_FAULT; // RQ11
                    end else if (cvMode && currentAtTopoff) begin
                        next_state = lcsc_pkg::LCSC_TOPOFF; // RQ5
                    end
                end
                lcsc_pkg::LCSC_TOPOFF: begin
                    if (tick && topExpired) begin
                        next_state = lcsc_pkg::LCSC_DONE; // RQ5
                    end
                end
                lcsc_pkg::LCSC_DONE: begin
                    if (batLow) begin
                        next_state = bat3v ? lcsc_pkg::LCSC_FAST : lcsc_pkg::LCSC_PREQUAL; // RQ6
                    end
                end
                lcsc_pkg::LCSC_FAULT: begin
                    next_state = lcsc_pkg::LCSC_FAULT; // RQ9
                end
                default: begin
                    next_state = lcsc_pkg::LCSC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state     <= lcsc_pkg::LCSC_IDLE;
            timer     <= 32'h0000_0000;
            halfPhase <= 1'b0;
            enPrev    <= 1'b0;
        end else begin
            state  <= next_state;
            enPrev <= allowed;
            if (next_state != state) begin
                timer     <= 32'h0000_0000; // RQ6
                halfPhase <= 1'b0;
            end else if (tick) begin
                halfPhase <= ~halfPhase;
                if (state != lcsc_pkg::LCSC_FAST || fastAdvance) begin
                    timer <= timer + 32'h0000_0001;
                end
            end
        end
    end

    // status blink and command outputs
    logic [8:0] blinkCount;
    logic       blinkLow;
    wire logic  active = state == lcsc_pkg::LCSC_PREQUAL || state == lcsc_pkg::LCSC_FAST;
    wire logic  faulted = state == lcsc_pkg::LCSC_FAULT;
    wire lcsc_pkg::lcsc_ma_t want =
        (state == lcsc_pkg::LCSC_PREQUAL) ? tenthMax :                     // RQ3
        (state == lcsc_pkg::LCSC_FAST || state == lcsc_pkg::LCSC_TOPOFF) ? progMax : // RQ4
        `LCSC_LIM_MA_ZERO;                                                  // RQ5
    wire lcsc_pkg::lcsc_ma_t next_cmd = (want > headroom) ? headroom : want; // RQ16

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            blinkCount <= 9'h000;
            blinkLow   <= 1'b0;
        end else if (!faulted) begin
            blinkCount <= 9'h000;
            blinkLow   <= 1'b1;
        end else if (tick) begin
            if (blinkCount == 9'(BLINK_HALF - 1)) begin
                blinkCount <= 9'h000;
                blinkLow   <= ~blinkLow; // RQ9
            end else begin
                blinkCount <= blinkCount + 9'h001;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            charge_status_n_out <= 1'b0;
            charge_status_n_oe  <= 1'b0;
            chargeCurrentCmd    <= 11'h000;
            inputLimitMa        <= 11'h000;
            inputConnected      <= 1'b0;
            chargerOn           <= 1'b0;
            faultLatched        <= 1'b0;
            chargeState         <= lcsc_pkg::LCSC_IDLE;
        end else begin
            charge_status_n_out <= 1'b0;
            charge_status_n_oe  <= active || (faulted && blinkLow); // RQ8 RQ9
            chargeCurrentCmd    <= next_cmd;
            inputLimitMa        <= (inputValid && !suspended) ? thermLimit : 11'h000;
            inputConnected      <= inputValid && !suspended; // RQ23
            chargerOn           <= allowed && (state != lcsc_pkg::LCSC_IDLE)
                                   && (state != lcsc_pkg::LCSC_DONE) && !faulted;
            faultLatched        <= faulted;
            chargeState         <= state;
        end
    end

    // converters
    lcsc_buck_if buckBus ();
    assign buckBus.tick      = tick;
    assign buckBus.enable    = buckEnS; // RQ24
    assign buckBus.railOk    = railOk;  // RQ19
    assign buckBus.sequenced = seqVar;  // RQ20

    lcsc_buck_seq buckSeq (
        .clock (clock),
        .rst_b (rst_b),
        .bus   (buckBus.buck)
    );

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            buck_one    <= 1'b0;
            buck_two    <= 1'b0;
            buck_three  <= 1'b0;
            buckRamping <= 3'h0;
            buckPwm     <= 3'h0;
        end else begin
            buck_one    <= buckBus.on[0];
            buck_two    <= buckBus.on[1];
            buck_three  <= buckBus.on[2];
            buckRamping <= buckBus.ramping;
            buckPwm     <= buckBus.on & loadHigh; // RQ21
        end
    end
endmodule
`default_nettype wire

// file: sim/lcsc_charge_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module lcsc_charge_ctrl_asserts (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // pins and flags
    input wire logic charge_enable_in,
    input wire logic buck_enable,
    input wire logic inputAbove4v,
    input wire logic systemRailOk,
    input wire logic [10:0] charge_current_set,
    input wire logic [2:0] buckLoad80ma,
    // outputs
    input wire logic charge_status_n_oe,
    input wire logic [10:0] chargeCurrentCmd,
    input wire logic [10:0] inputLimitMa,
    input wire logic inputConnected,
    input wire logic chargerOn,
    input wire logic faultLatched,
    input wire lcsc_pkg::lcsc_state_t chargeState,
    input wire logic buck_one,
    input wire logic buck_two,
    input wire logic buck_three,
    input wire logic [2:0] buckPwm
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // 8-cycle windows cover the synchronisers
    sequence s_railLow; !systemRailOk [*8]; endsequence
    sequence s_bucksOff; !buck_enable [*8]; endsequence
    sequence s_limSteady; $stable(inputLimitMa) [*3]; endsequence
    property p_uvlo; s_railLow |-> !(buck_one || buck_two || buck_three); endproperty
    a_uvlo: assert property (p_uvlo) else $error("converter on below lockout");
    property p_bucksOff; s_bucksOff |-> !(buck_one || buck_two || buck_three); endproperty
    a_bucksOff: assert property (p_bucksOff) else $error("converter on while disabled");
    property p_chgOff; !charge_enable_in [*8] |-> !chargerOn && !faultLatched; endproperty
    a_chgOff: assert property (p_chgOff) else $error("charger active while disabled");
    property p_noInput; !inputAbove4v [*8] |-> !inputConnected && !chargerOn; endproperty
    a_noInput: assert property (p_noInput) else $error("invalid input still connected");
    property p_fastSts; (chargeState == lcsc_pkg::LCSC_FAST) [*3] |-> charge_status_n_oe; endproperty
    a_fastSts: assert property (p_fastSts) else $error("status released in fast charge");
    property p_done;
        chargeState == lcsc_pkg::LCSC_DONE |-> !charge_status_n_oe && chargeCurrentCmd == 11'h000;
    endproperty
    a_done: assert property (p_done) else $error("charging in done state");
    property p_preqCur;
        chargeState == lcsc_pkg::LCSC_PREQUAL && charge_current_set >= 11'h0C8
            && charge_current_set <= 11'h3E8 |-> chargeCurrentCmd <= charge_current_set / 11'h00A;
    endproperty
    a_preqCur: assert property (p_preqCur) else $error("prequal current too high");
    property p_limit; s_limSteady |-> chargeCurrentCmd <= inputLimitMa; endproperty
    a_limit: assert property (p_limit) else $error("charge above input limit");
    property p_skip; (buckLoad80ma == 3'h0) [*6] |-> buckPwm == 3'h0; endproperty
    a_skip: assert property (p_skip) else $error("fixed switching at light load");
endmodule
bind lcsc_charge_ctrl lcsc_charge_ctrl_asserts chk (.*);
`default_nettype wire

// file: sim/lcsc_host.sv
`timescale 1ns/1ps
`default_nettype none
module lcsc_host (
    // clock
    input  wire logic clock,
    // host pins
    output logic      charge_enable_in,
    output logic      limit_select_hi,
    output logic      limit_select_lo,
    output logic      buck_enable
);
    initial begin
        charge_enable_in = 1'b0;
        {limit_select_hi, limit_select_lo} = 2'h0;
        buck_enable = 1'b0;
    end
    // pins move just after an edge, all at once
    task automatic drive(input logic ce, input logic [1:0] code, input logic be);
        @(posedge clock);
        #1;
        charge_enable_in = ce;
        {limit_select_hi, limit_select_lo} = code;
        buck_enable = be;
    endtask
endmodule
`default_nettype wire

// file: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clock, rst_b, seqVar, in4v, inBat, bat3v, batRestart, cv, railOk, o;
    logic [10:0] chgSet, meas, load;
    logic [7:0]  dieTemp;
    logic [2:0]  load80;
    wire logic   ce, limHi, limLo, buckEn, stsOut, stsOe, inConn, chgOn, fault, b1, b2, b3;
    wire logic [10:0] cmd, lim;
    wire logic [2:0]  ramp, pwm;
    wire lcsc_pkg::lcsc_state_t st;
    int          fail_count, n_tests, w;
    logic [10:0] limTab [4] = '{11'h3E8, 11'h1DB, 11'h05F, 11'h000};

    lcsc_host host (.clock(clock), .charge_enable_in(ce), .limit_select_hi(limHi),
        .limit_select_lo(limLo), .buck_enable(buckEn));
    lcsc_charge_ctrl #(.TICK_DIV(10), .PREQUAL_TICKS(20), .TOPOFF_TICKS(20), .FAST_TICKS(30)) dut (
        .clock(clock), .rst_b(rst_b), .charge_enable_in(ce), .limit_select_hi(limHi),
        .limit_select_lo(limLo), .buck_enable(buckEn), .sequencedVariant(seqVar),
        .inputAbove4v(in4v), .inputAboveBattery(inBat), .batteryAbove3v(bat3v),
        .batteryBelowRestart(batRestart), .constantVoltage(cv), .systemRailOk(railOk),
        .charge_current_set(chgSet), .chargeCurrentMeas(meas), .system_load_current(load),
        .dieTemp(dieTemp), .buckLoad80ma(load80), .charge_status_n_out(stsOut),
        .charge_status_n_oe(stsOe), .chargeCurrentCmd(cmd), .inputLimitMa(lim),
        .inputConnected(inConn), .chargerOn(chgOn), .faultLatched(fault), .chargeState(st),
        .buck_one(b1), .buck_two(b2), .buck_three(b3), .buckRamping(ramp), .buckPwm(pwm));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic results;
        if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // bounded poll; a hang shows as a state mismatch
    task automatic waitSt(input logic [5:0] s, input int n);
        for (int i = 0; i < n && st !== s; i++) step(1);
        chk("state", 16'(s), 16'(st));
    endtask

    task automatic start(input logic bat);
        bat3v = bat;
        host.drive(1'b0, 2'h0, 1'b0);
        step(10);
        host.drive(1'b1, 2'h0, 1'b0);
    endtask

    task automatic t_limits;
        for (int c = 1; c < 5; c++) begin
            host.drive(1'b0, 2'(c % 4), 1'b0);
            step(80);
            chk("limit", 16'(limTab[c % 4]), 16'(lim));
        end
        host.drive(1'b0, 2'h3, 1'b0);
        host.drive(1'b0, 2'h0, 1'b0);
        step(60);
        chk("glitch", 16'h03E8, 16'(lim));
        dieTemp = 8'h6E;
        step(4);
        chk("taper", 16'h01F4, 16'(lim));
        dieTemp = 8'h78;
        step(4);
        chk("taper", 16'h0000, 16'(lim));
        dieTemp = 8'h19;
    endtask

    task automatic t_charge;
        start(1'b0);
        waitSt(6'h02, 20);
        step(2);
        chk("preqCur", 16'h0032, 16'(cmd));
        bat3v = 1'b1;
        waitSt(6'h04, 20);
        step(2);
        chk("fastCur", 16'h01F4, 16'(cmd));
        chk("statusOe", 16'h0001, 16'(stsOe));
        load = 11'h2BC;
        step(4);
        chk("loadCur", 16'h012C, 16'(cmd));
        load = 11'h000;
        step(180);
        chk("fastRun", 16'h0004, 16'(st));
        waitSt(6'h20, 200);
        o = stsOe;
        for (w = 0; w < 2600 && stsOe === o; w++) step(1);
        o = stsOe;
        for (w = 0; w < 2600 && stsOe === o; w++) step(1);
        chk("blink", 16'h09C4, 16'(w));
        host.drive(1'b0, 2'h0, 1'b0);
        waitSt(6'h01, 20);
        chk("fault", 16'h0000, 16'(fault));
    endtask

    task automatic t_rates;
        meas = 11'h0C8;
        start(1'b1);
        waitSt(6'h04, 20);
        step(450);
        chk("halfRate", 16'h0004, 16'(st));
        waitSt(6'h20, 250);
        host.drive(1'b1, 2'h3, 1'b0);
        waitSt(6'h01, 100);
        meas = 11'h032;
        host.drive(1'b1, 2'h0, 1'b0);
        waitSt(6'h04, 100);
        step(1000);
        chk("paused", 16'h0004, 16'(st));
        meas = 11'h03C;
        cv = 1'b1;
        step(200);
        chk("cvRun", 16'h0004, 16'(st));
        waitSt(6'h20, 200);
        cv = 1'b0;
        meas = 11'h1F4;
    endtask

    task automatic t_prequal;
        start(1'b0);
        waitSt(6'h02, 20);
        step(150);
        chk("preqRun", 16'h0002, 16'(st));
        waitSt(6'h20, 100);
        in4v = 1'b0;
        step(12);
        chk("removed", 16'h0001, 16'(st));
        chk("inConn", 16'h0000, 16'(inConn));
        in4v = 1'b1;
    endtask

    task automatic t_topoff;
        start(1'b1);
        waitSt(6'h04, 20);
        step(150);
        cv = 1'b1;
        meas = 11'h028;
        waitSt(6'h08, 20);
        chk("topoffOe", 16'h0000, 16'(stsOe));
        step(150);
        chk("topoffRun", 16'h0008, 16'(st));
        waitSt(6'h10, 100);
        chk("doneCur", 16'h0000, 16'(cmd));
        batRestart = 1'b1;
        cv = 1'b0;
        meas = 11'h1F4;
        waitSt(6'h04, 20);
        batRestart = 1'b0;
        step(200);
        chk("timerReset", 16'h0004, 16'(st));
    endtask

    task automatic t_bucks;
        host.drive(1'b0, 2'h0, 1'b1);
        step(60);
        chk("bucks", 16'h0007, 16'({b1, b2, b3}));
        load80 = 3'h5;
        step(8);
        chk("pwm", 16'h0005, 16'(pwm));
        railOk = 1'b0;
        step(10);
        chk("uvlo", 16'h0000, 16'({b1, b2, b3}));
        railOk = 1'b1;
        seqVar = 1'b1;
        host.drive(1'b0, 2'h0, 1'b0);
        step(10);
        host.drive(1'b0, 2'h0, 1'b1);
        for (w = 0; w < 100 && b1 !== 1'b1; w++) step(1);
        chk("seqOrder", 16'h0004, 16'({b1, b2, b3}));
        step(100);
        chk("seqDone", 16'h0007, 16'({b1, b2, b3}));
    endtask

    initial begin
        {rst_b, seqVar, bat3v, batRestart, cv, load80} = '0;
        {in4v, inBat, railOk} = 3'h7;
        chgSet = 11'h1F4;
        meas = 11'h1F4;
        load = 11'h000;
        dieTemp = 8'h19;
        fail_count = 0;
        n_tests = 0;
        repeat (16) @(posedge clock);
        #1 rst_b = 1'b1;
        step(8);
        t_limits();
        t_charge();
        t_rates();
        t_prequal();
        t_topoff();
        t_bucks();
        results();
    end

    // about 9000 cycles needed
    initial begin
        repeat (40000) @(posedge clock);
        fail_count++;
        results();
    end
endmodule
`default_nettype wire
